// file: core/ast_pkg.sv
// Package for the asynchronous serial transceiver: register map, fields, timing counts, carriers.
// Assumes an APB master on the same clock as the transceiver.
package ast_pkg;
  // Register byte offsets
  localparam logic [7:0] AST_OFF_MODE = 8'h00;
  localparam logic [7:0] AST_OFF_STAT = 8'h04;
  localparam logic [7:0] AST_OFF_DIV = 8'h08;
  localparam logic [7:0] AST_OFF_TXD = 8'h0c;
  localparam logic [7:0] AST_OFF_RXD = 8'h10;
  // Mode register fields
  localparam int AST_MODE_ON = 15;
  localparam int AST_MODE_SIMPLEX = 11;
  localparam int AST_MODE_PIN_LO = 8;
  localparam int AST_MODE_ADDR_DET = 5;
  localparam int AST_MODE_HS = 3;
  localparam int AST_MODE_PD_LO = 1;
  localparam int AST_MODE_STOP2 = 0;
  localparam logic [15:0] AST_MODE_MASK = 16'h8b2f;
  localparam logic [15:0] AST_MODE_RST = 16'h0000;
  localparam logic [15:0] AST_DIV_RST = 16'h0000;
  // Status register fields
  localparam int AST_ST_TXSEL_LO = 14;
  localparam int AST_ST_BRK = 11;
  localparam int AST_ST_TXEN = 10;
  localparam int AST_ST_TXFULL = 9;
  localparam int AST_ST_TXIDLE = 8;
  localparam int AST_ST_RXSEL_LO = 6;
  localparam int AST_ST_PARITY_ERROR_FLAG = 3;
  localparam int AST_ST_FRAMING_ERROR_FLAG = 2;
  localparam int AST_ST_OVERRUN_ERROR_FLAG = 1;
  localparam int AST_ST_RXAV = 0;
  // Oversampling and frame timing in baud ticks and bits; queue depth, receive trigger, pin and parity codes
  localparam logic [3:0] AST_OS_STD = 4'hf;
  localparam logic [3:0] AST_OS_HS = 4'h3;
  localparam logic [3:0] AST_HALF_STD = 4'h7;
  localparam logic [3:0] AST_HALF_HS = 4'h1;
  localparam logic [3:0] AST_BRK_BITS = 4'hc;
  localparam logic [2:0] AST_FIFO_DEPTH = 3'h4;
  localparam logic [2:0] AST_RX_TRIG3 = 3'h3;
  localparam logic [1:0] AST_PIN_CTS = 2'h2;
  localparam logic [1:0] AST_PIN_BCLK = 2'h3;
  localparam logic [1:0] AST_PD_ODD = 2'h2;
  localparam logic [1:0] AST_PD_NINE = 2'h3;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010, TX_PAR = 3'b011, TX_STOP = 3'b100, TX_BREAK = 3'b101
  } ast_tx_st_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010, RX_PAR = 3'b011, RX_STOP = 3'b100
  } ast_rx_st_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } ast_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ast_apb_rsp_t;

  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] div;
    logic [15:0] brg_cnt;
    logic [1:0] txsel;
    logic [1:0] rxsel;
    logic brk;
    logic txen;
    logic overrun_error_flag;
    ast_tx_st_t tx_st;
    logic [3:0] tx_os;
    logic [3:0] tx_bit;
    logic [8:0] tx_sh;
    logic tx_par;
    logic [3:0][8:0] txf_mem;
    logic [1:0] txf_rd;
    logic [2:0] txf_cnt;
    ast_rx_st_t rx_st;
    logic [3:0] rx_os;
    logic [3:0] rx_bit;
    logic [8:0] rx_sh;
    logic rx_par;
    logic [3:0][10:0] rxf_mem;
    logic [1:0] rxf_rd;
    logic [2:0] rxf_cnt;
    logic rd_arm;
    logic [2:0] rx_sync;
    logic rx_lvl;
    logic [2:0] cts_sync;
    logic cts_lvl;
    logic ten_dly;
    logic tx_irq;
    logic rx_irq;
    logic txd;
    logic rts_n;
    ast_apb_rsp_t rsp;
  } ast_state_t;
endpackage

// file: core/ast_uart.sv
// Asynchronous serial transceiver: baud generator, 4-deep transmit and receive queues,
// framing, break, error flags, interrupt strobes, handshake pins and 16x baud clock.
// Assumes an APB master on clk_in; serial and handshake pins are asynchronous to it.
// Notes on behaviour
// [R1] Baud generator is a free-running 16-bit timer, period set by divisor.
// [R2] Standard speed: bit rate is clock over 16 times divisor plus one.
// [R3] High speed: bit rate is clock over 4 times divisor plus one.
// [R4] Writing the divisor clears the baud timer at once.
// [R5] Setting transmit enable raises a transmit interrupt two cycles later.
// [R6] A byte written reaches an idle shift register on the next baud tick and starts shifting.
// [R7] Setting transmit enable restarts the baud clock, so a queued byte leaves on the first tick of the restarted clock.
// [R8] Software writes both low bytes of transmit data in 9-bit mode.
// [R9] Transmit interrupt condition follows tx_irq_select.
// [R10] Receive interrupt on received characters, trigger chosen by rx_irq_select.
// [R11] With break and enable set, next written character starts a Break and is discarded.
// [R12] After the Break, hardware clears break_request and sends the next queued character.
// [R13] Software queues the sync value 55h after the dummy Break character.
// [R14] Overrun flag stays set until software clears it.
// [R15] Reading receive data pops the queue and shows the next character's error flags.
// [R16] Transmit queue holds up to four characters ahead of the shift register.
// [R17] Receive queue holds up to four characters.
// [R18] Even, odd or no parity with 8 bits, a 9-bit option, one or two stops.
// [R19] Parity, framing and overrun errors are each reported as flags.
// [R20] In 9-bit mode address detect keeps only characters whose ninth bit is one.
// [R21] The 16x baud clock exists only at standard speed.
// [R22] Pin usage 11 with module on drives the 16x baud clock on the request pin.
// [R23] Pin usage enables the handshake pins; the simplex bit selects simplex or flow-control handshaking on them.
// [R24] Frame: low start, data LSB first, optional parity, one or two high stops.
// [R25] Receiver samples bit centres from sixteen ticks at standard speed, four at high speed; low stop bit is a framing error.
`timescale 1ns/1ps
module ast_uart
  import ast_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // APB slave
  input wire ast_apb_req_t apb_req_in,
  output ast_apb_rsp_t apb_rsp_out,
  // Serial and handshake pins
  input wire logic serial_in_pin_in,
  input wire logic clear_to_send_pin_n_in,
  output logic serial_out_pin_out,
  output logic request_to_send_pin_n_out,
  // Interrupt strobes
  output logic tx_irq_out,
  output logic rx_irq_out
);

  ast_state_t s_r;
  ast_state_t s_nxt;
  logic on, hs, nine, par_en, tick, cts_ok, setup, acc, mapped, wr_txen_set;
  logic tx_push, tx_pop, tx_done, rx_push, rx_ok, rx_pop;
  logic [1:0] pd, pins, tx_wi, rx_wi;
  logic [3:0] lim, half, last_bit;
  logic [8:0] tx_head, rx_d9;
  logic [10:0] rx_head;
  logic [15:0] stat_rd;

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] ast_merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
    ast_merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    s_nxt = s_r;
    on = s_r.mode[AST_MODE_ON];
    hs = s_r.mode[AST_MODE_HS];
    pd = s_r.mode[AST_MODE_PD_LO +: 2];
    pins = s_r.mode[AST_MODE_PIN_LO +: 2];
    nine = (pd == AST_PD_NINE);
    par_en = (pd == 2'h1) || (pd == AST_PD_ODD); // R18
    lim = hs ? AST_OS_HS : AST_OS_STD; // R2 R3
    half = hs ? AST_HALF_HS : AST_HALF_STD; // R25
    last_bit = nine ? 4'h8 : 4'h7;
    tick = (s_r.brg_cnt == s_r.div);
    cts_ok = (pins != AST_PIN_CTS) || !s_r.cts_lvl; // R23
    tx_head = s_r.txf_mem[s_r.txf_rd];
    rx_head = s_r.rxf_mem[s_r.rxf_rd];
    tx_wi = s_r.txf_rd + s_r.txf_cnt[1:0];
    rx_wi = s_r.rxf_rd + s_r.rxf_cnt[1:0];
    rx_d9 = nine ? s_r.rx_sh : {1'b0, s_r.rx_sh[8:1]};
    setup = apb_req_in.psel && !apb_req_in.penable;
    acc = apb_req_in.psel && apb_req_in.penable && s_r.rsp.pready;
    mapped = (apb_req_in.paddr == AST_OFF_MODE) || (apb_req_in.paddr == AST_OFF_STAT) ||
             (apb_req_in.paddr == AST_OFF_DIV) || (apb_req_in.paddr == AST_OFF_TXD) ||
             (apb_req_in.paddr == AST_OFF_RXD);
    wr_txen_set = 1'b0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    tx_done = 1'b0;
    rx_push = 1'b0;
    rx_ok = 1'b0;
    rx_pop = 1'b0;
    stat_rd = '0;
    stat_rd[AST_ST_TXSEL_LO +: 2] = s_r.txsel;
    stat_rd[AST_ST_BRK] = s_r.brk;
    stat_rd[AST_ST_TXEN] = s_r.txen;
    stat_rd[AST_ST_TXFULL] = (s_r.txf_cnt == AST_FIFO_DEPTH);
    stat_rd[AST_ST_TXIDLE] = (s_r.tx_st == TX_IDLE) && (s_r.txf_cnt == 3'h0);
    stat_rd[AST_ST_RXSEL_LO +: 2] = s_r.rxsel;
    stat_rd[AST_ST_PARITY_ERROR_FLAG] = (s_r.rxf_cnt != 3'h0) && rx_head[10]; // R19
    stat_rd[AST_ST_FRAMING_ERROR_FLAG] = (s_r.rxf_cnt != 3'h0) && rx_head[9]; // R19
    stat_rd[AST_ST_OVERRUN_ERROR_FLAG] = s_r.overrun_error_flag;
    stat_rd[AST_ST_RXAV] = (s_r.rxf_cnt != 3'h0);

    // Free-running baud timer
    s_nxt.brg_cnt = tick ? 16'h0000 : s_r.brg_cnt + 16'h0001; // R1

    // Pin synchronisers, level taken when second and third stages agree
    s_nxt.rx_sync = {s_r.rx_sync[1:0], serial_in_pin_in};
    s_nxt.cts_sync = {s_r.cts_sync[1:0], clear_to_send_pin_n_in};
    if (s_r.rx_sync[2] == s_r.rx_sync[1]) begin
      s_nxt.rx_lvl = s_r.rx_sync[2];
    end
    if (s_r.cts_sync[2] == s_r.cts_sync[1]) begin
      s_nxt.cts_lvl = s_r.cts_sync[2];
    end

    // APB response prepared in the setup cycle
    s_nxt.rsp.pready = setup;
    s_nxt.rsp.pslverr = setup && !mapped;
    s_nxt.rd_arm = setup && (s_r.rxf_cnt != 3'h0);
    if (setup) begin
      case (apb_req_in.paddr)
        AST_OFF_MODE: s_nxt.rsp.prdata = {16'h0000, s_r.mode};
        AST_OFF_STAT: s_nxt.rsp.prdata = {16'h0000, stat_rd};
        AST_OFF_DIV: s_nxt.rsp.prdata = {16'h0000, s_r.div};
        AST_OFF_RXD: s_nxt.rsp.prdata = (s_r.rxf_cnt != 3'h0) ? {23'h000000, rx_head[8:0]} : 32'h00000000;
        default: s_nxt.rsp.prdata = 32'h00000000;
      endcase
    end

    // Register writes and read side effects at the access edge
    if (acc && apb_req_in.pwrite) begin
      case (apb_req_in.paddr)
        AST_OFF_MODE: s_nxt.mode = ast_merge(s_r.mode, apb_req_in.pwdata, apb_req_in.pstrb) & AST_MODE_MASK;
        AST_OFF_STAT: begin
          if (apb_req_in.pstrb[1]) begin
            s_nxt.txsel = apb_req_in.pwdata[AST_ST_TXSEL_LO +: 2];
            s_nxt.brk = apb_req_in.pwdata[AST_ST_BRK];
            s_nxt.txen = apb_req_in.pwdata[AST_ST_TXEN];
            wr_txen_set = apb_req_in.pwdata[AST_ST_TXEN] && !s_r.txen;
          end
          if (apb_req_in.pstrb[0]) begin
            s_nxt.rxsel = apb_req_in.pwdata[AST_ST_RXSEL_LO +: 2];
            s_nxt.overrun_error_flag = s_r.overrun_error_flag && apb_req_in.pwdata[AST_ST_OVERRUN_ERROR_FLAG]; // R14
          end
        end
        AST_OFF_DIV: begin
          s_nxt.div = ast_merge(s_r.div, apb_req_in.pwdata, apb_req_in.pstrb);
          s_nxt.brg_cnt = 16'h0000; // R4
        end
        AST_OFF_TXD: tx_push = nine ? (apb_req_in.pstrb[1:0] == 2'h3) : apb_req_in.pstrb[0]; // R8 R6
        default: ;
      endcase
    end
    rx_pop = acc && !apb_req_in.pwrite && (apb_req_in.paddr == AST_OFF_RXD) && s_r.rd_arm; // R15

    // Enabling the transmitter restarts the baud clock and schedules an interrupt
    if (wr_txen_set) begin
      s_nxt.brg_cnt = 16'h0000; // R7
      s_nxt.tx_os = 4'h0; // R7
    end
    s_nxt.ten_dly = wr_txen_set; // R5

    // Transmit engine; a frame starts on a baud tick so the start bit lasts a full bit
    if (s_r.tx_st == TX_IDLE) begin
      if (on && s_r.txen && (s_r.txf_cnt != 3'h0) && cts_ok && tick) begin // R6 R7
        tx_pop = 1'b1; // R6
        s_nxt.tx_os = 4'h0;
        s_nxt.tx_bit = 4'h0;
        if (s_r.brk) begin
          s_nxt.tx_st = TX_BREAK; // R11
        end else begin
          s_nxt.tx_sh = tx_head;
          s_nxt.tx_par = (^tx_head[7:0]) ^ (pd == AST_PD_ODD); // R18
          s_nxt.tx_st = TX_START;
        end
      end
    end else if (tick) begin
      if (s_r.tx_os != lim) begin
        s_nxt.tx_os = s_r.tx_os + 4'h1;
      end else begin
        s_nxt.tx_os = 4'h0;
        case (s_r.tx_st)
          TX_START: s_nxt.tx_st = TX_DATA;
          TX_DATA: begin
            s_nxt.tx_sh = {1'b0, s_r.tx_sh[8:1]}; // R24
            s_nxt.tx_bit = s_r.tx_bit + 4'h1;
            if (s_r.tx_bit == last_bit) begin
              s_nxt.tx_bit = 4'h0;
              s_nxt.tx_st = par_en ? TX_PAR : TX_STOP;
            end
          end
          TX_PAR: s_nxt.tx_st = TX_STOP;
          TX_STOP: begin
            if (s_r.mode[AST_MODE_STOP2] && (s_r.tx_bit == 4'h0)) begin
              s_nxt.tx_bit = 4'h1; // R18
            end else begin
              s_nxt.tx_st = TX_IDLE;
              tx_done = 1'b1;
            end
          end
          TX_BREAK: begin
            s_nxt.tx_bit = s_r.tx_bit + 4'h1;
            if (s_r.tx_bit == AST_BRK_BITS) begin
              s_nxt.brk = 1'b0; // R12
              s_nxt.tx_bit = 4'h1;
              s_nxt.tx_st = TX_STOP;
            end
          end
          default: s_nxt.tx_st = TX_IDLE;
        endcase
      end
    end

    // Receive engine, oversampled from the baud tick
    if (tick) begin
      case (s_r.rx_st)
        RX_IDLE: begin
          if (!s_r.rx_lvl) begin
            s_nxt.rx_st = RX_START;
            s_nxt.rx_os = 4'h0;
          end
        end
        RX_START: begin
          if (s_r.rx_os == half) begin
            s_nxt.rx_os = 4'h0; // R25
            s_nxt.rx_bit = 4'h0;
            s_nxt.rx_st = s_r.rx_lvl ? RX_IDLE : RX_DATA;
          end else begin
            s_nxt.rx_os = s_r.rx_os + 4'h1;
          end
        end
        RX_DATA: begin
          if (s_r.rx_os == lim) begin
            s_nxt.rx_os = 4'h0;
            s_nxt.rx_sh = {s_r.rx_lvl, s_r.rx_sh[8:1]}; // R25
            s_nxt.rx_bit = s_r.rx_bit + 4'h1;
            if (s_r.rx_bit == last_bit) begin
              s_nxt.rx_st = par_en ? RX_PAR : RX_STOP;
            end
          end else begin
            s_nxt.rx_os = s_r.rx_os + 4'h1;
          end
        end
        RX_PAR: begin
          if (s_r.rx_os == lim) begin
            s_nxt.rx_os = 4'h0;
            s_nxt.rx_par = s_r.rx_lvl;
            s_nxt.rx_st = RX_STOP;
          end else begin
            s_nxt.rx_os = s_r.rx_os + 4'h1;
          end
        end
        RX_STOP: begin
          if (s_r.rx_os == lim) begin
            rx_push = !(nine && s_r.mode[AST_MODE_ADDR_DET] && !rx_d9[8]); // R20
            s_nxt.rx_st = RX_IDLE;
          end else begin
            s_nxt.rx_os = s_r.rx_os + 4'h1;
          end
        end
        default: s_nxt.rx_st = RX_IDLE;
      endcase
    end

    // Module off: engines held idle
    if (!on) begin
      s_nxt.tx_st = TX_IDLE;
      s_nxt.rx_st = RX_IDLE;
      tx_pop = 1'b0;
      rx_push = 1'b0;
    end

    // Transmit queue
    if (tx_push && !((s_r.txf_cnt == AST_FIFO_DEPTH) && !tx_pop)) begin
      s_nxt.txf_mem[tx_wi] = nine ? apb_req_in.pwdata[8:0] : {1'b0, apb_req_in.pwdata[7:0]}; // R16
    end else begin
      tx_push = 1'b0;
    end
    s_nxt.txf_cnt = s_r.txf_cnt + {2'b00, tx_push} - {2'b00, tx_pop}; // R16
    if (tx_pop) begin
      s_nxt.txf_rd = s_r.txf_rd + 2'h1;
    end

    // Receive queue with overrun detection
    rx_ok = rx_push && !((s_r.rxf_cnt == AST_FIFO_DEPTH) && !rx_pop);
    if (rx_push && !rx_ok) begin
      s_nxt.overrun_error_flag = 1'b1; // R14 R19
    end
    if (rx_ok) begin
      s_nxt.rxf_mem[rx_wi] = {par_en && ((^rx_d9[7:0]) ^ s_r.rx_par ^ (pd == AST_PD_ODD)),
                             !s_r.rx_lvl, rx_d9}; // R19 R25
    end
    s_nxt.rxf_cnt = s_r.rxf_cnt + {2'b00, rx_ok} - {2'b00, rx_pop}; // R17
    if (rx_pop) begin
      s_nxt.rxf_rd = s_r.rxf_rd + 2'h1; // R15
    end

    // Interrupt strobes
    case (s_r.txsel)
      2'h1: s_nxt.tx_irq = s_r.ten_dly || (tx_done && (s_nxt.txf_cnt == 3'h0)); // R9
      2'h2: s_nxt.tx_irq = s_r.ten_dly || (tx_pop && (s_r.txf_cnt == 3'h1)); // R9
      default: s_nxt.tx_irq = s_r.ten_dly || tx_pop; // R5 R9
    endcase
    case (s_r.rxsel)
      2'h2: s_nxt.rx_irq = rx_ok && (s_nxt.rxf_cnt == AST_RX_TRIG3); // R10
      2'h3: s_nxt.rx_irq = rx_ok && (s_nxt.rxf_cnt == AST_FIFO_DEPTH); // R10
      default: s_nxt.rx_irq = rx_ok; // R10
    endcase

    // Serial line level from the next transmit state
    case (s_nxt.tx_st)
      TX_START, TX_BREAK: s_nxt.txd = 1'b0; // R24 R11
      TX_DATA: s_nxt.txd = s_nxt.tx_sh[0]; // R24
      TX_PAR: s_nxt.txd = s_nxt.tx_par; // R24
      default: s_nxt.txd = 1'b1; // R24
    endcase

    // Request pin: idle, handshake or 16x baud clock
    if (!on || (pins == 2'h0)) begin
      s_nxt.rts_n = 1'b1;
    end else if (pins == AST_PIN_BCLK) begin
      s_nxt.rts_n = !hs && (s_r.brg_cnt <= {1'b0, s_r.div[15:1]}); // R21 R22
    end else if (s_r.mode[AST_MODE_SIMPLEX]) begin
      s_nxt.rts_n = (s_nxt.tx_st == TX_IDLE); // R23
    end else begin
      s_nxt.rts_n = (s_nxt.rxf_cnt == AST_FIFO_DEPTH); // R23
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_r <= '0;
      s_r.rx_sync <= 3'h7;
      s_r.rx_lvl <= 1'b1;
      s_r.cts_sync <= 3'h7;
      s_r.cts_lvl <= 1'b1;
      s_r.txd <= 1'b1;
      s_r.rts_n <= 1'b1;
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign apb_rsp_out = s_r.rsp;
  assign serial_out_pin_out = s_r.txd;
  assign request_to_send_pin_n_out = s_r.rts_n;
  assign tx_irq_out = s_r.tx_irq;
  assign rx_irq_out = s_r.rx_irq;

  // Checks on the design's own behaviour
  a_div_clears_brg: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R4
    (ce_in && acc && apb_req_in.pwrite && (apb_req_in.paddr == AST_OFF_DIV)) |=> (s_r.brg_cnt == 16'h0000))
    else $error("divisor write did not clear baud timer");
  a_brg_in_range: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R1
    (s_r.brg_cnt <= s_r.div))
    else $error("baud timer passed divisor");
  a_txen_irq_two: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R5
    (ce_in && wr_txen_set) ##1 ce_in |=> tx_irq_out)
    else $error("transmit interrupt not two cycles after enable");
  a_start_low: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R24
    ((s_r.tx_st == TX_START) || (s_r.tx_st == TX_BREAK)) |-> !serial_out_pin_out)
    else $error("start or break bit not low");
  a_stop_high: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R24
    ((s_r.tx_st == TX_STOP) || (s_r.tx_st == TX_IDLE)) |-> serial_out_pin_out)
    else $error("stop bit or idle not high");
  a_break_clears: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R12
    (s_r.tx_st == TX_BREAK) ##1 (s_r.tx_st == TX_STOP) |-> !s_r.brk)
    else $error("break request left set after break");
  a_overrun_error_flag_sticky: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R14
    (s_r.overrun_error_flag && !(acc && apb_req_in.pwrite && (apb_req_in.paddr == AST_OFF_STAT))) |=> s_r.overrun_error_flag)
    else $error("overrun flag dropped without software clear");
  a_fifo_bound: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R16 R17
    (s_r.txf_cnt <= AST_FIFO_DEPTH) && (s_r.rxf_cnt <= AST_FIFO_DEPTH))
    else $error("queue count above depth");
  a_rx_pop_count: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R15
    (ce_in && rx_pop && !rx_ok) |=> (s_r.rxf_cnt == $past(s_r.rxf_cnt) - 3'h1))
    else $error("receive read did not pop");
  a_cts_holds: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R23
    ((pins == AST_PIN_CTS) && s_r.cts_lvl && (s_r.tx_st == TX_IDLE)) |=> (s_r.tx_st == TX_IDLE))
    else $error("transmit started while clear-to-send inactive");

endmodule

// file: verif/ast_peer.sv
// Remote serial peer: drives the receive line of the transceiver, times and decodes its transmit line.
// Assumes the bench clock; bit periods are given in clock cycles, receive line idles high.
`timescale 1ns/1ps
module ast_peer (
  // Clock
  input wire logic clk_in,
  // Serial lines
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'b1;

  // One 8-bit frame, no parity; the stop level is the caller's choice
  task automatic send(input logic [7:0] d, input logic stop, input int bp);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (bp) @(posedge clk_in);
    end
    line_out <= 1'b1;
    @(posedge clk_in);
  endtask

  // Cycles from a falling edge of the line to its next rise
  task automatic low_len(output int n);
    n = 0;
    wait (line_in === 1'b0);
    while (line_in === 1'b0) begin
      @(posedge clk_in);
      #1;
      n++;
    end
  endtask

  // Eight data bits, LSB first, then the stop level in bit 8
  task automatic recv(output logic [8:0] d, input int bp);
    wait (line_in === 1'b0);
    repeat (bp / 2) @(posedge clk_in);
    for (int i = 0; i < 9; i++) begin
      repeat (bp) @(posedge clk_in);
      #1 d[i] = line_in;
    end
  endtask
endmodule

// file: verif/tb_async_serial_transceiver.sv
// Bench for the serial transceiver: APB register tasks, peer-driven frames and compares.
// Assumes the 25 MHz clock and the register map of the package.
`timescale 1ns/1ps
module tb_async_serial_transceiver
  import ast_pkg::*;
;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic ce_in = 1'b1;
  logic cts_n = 1'b0;
  ast_apb_req_t apb_req = '0;
  ast_apb_rsp_t apb_rsp;
  logic sout, sin, rts_n, txirq, rxirq, err;
  logic [31:0] q;
  logic [8:0] d;
  int miscompares = 0, check_count = 0, cyc = 0, irq_at = 0, rx_irqs = 0, wc = 0, n = 0;
  logic [31:0] mode_v [2] = '{32'h8000, 32'h8008};
  int div_v [2] = '{2, 1};
  int bp_v [2] = '{48, 8};

  ast_uart u_ast_uart (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in), .apb_req_in(apb_req),
    .apb_rsp_out(apb_rsp), .serial_in_pin_in(sin), .clear_to_send_pin_n_in(cts_n),
    .serial_out_pin_out(sout), .request_to_send_pin_n_out(rts_n), .tx_irq_out(txirq), .rx_irq_out(rxirq));
  ast_peer u_ast_peer (.clk_in(clk_in), .line_in(sout), .line_out(sin));

  // 40 ns clock
  initial forever #20 clk_in = ~clk_in;

  // Cycle count, first transmit interrupt, receive interrupts, timeout
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (txirq === 1'b1 && irq_at == 0) irq_at <= cyc;
    if (rxirq === 1'b1) rx_irqs <= rx_irqs + 1;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd, pstrb: 4'hf};
    @(posedge clk_in);
    apb_req.penable <= 1'b1;
    do @(posedge clk_in); while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    wc = cyc;
    apb_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(AST_OFF_MODE, 32'hffffffff, {16'h0, AST_MODE_RST});
    rd(AST_OFF_DIV, 32'hffffffff, {16'h0, AST_DIV_RST});
    rd(8'h14, 32'h0, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Five bytes while disabled: four queue, the fifth is dropped
    apb(1'b1, AST_OFF_MODE, 32'h8000);
    for (int i = 1; i <= 5; i++) apb(1'b1, AST_OFF_TXD, 32'(i * 8'h11));
    rd(AST_OFF_STAT, 32'h200, 32'h200);
    apb(1'b1, AST_OFF_STAT, 32'h4400);
    for (int i = 1; i <= 4; i++) begin
      u_ast_peer.recv(d, 16);
      chk({23'h0, d}, 32'(9'h100 | i * 8'h11));
    end
    chk(32'(irq_at - wc), 32'h2);
    repeat (32) @(posedge clk_in);
    rd(AST_OFF_STAT, 32'h100, 32'h100);
    // Good frame, then a frame with a low stop bit
    u_ast_peer.send(8'h3c, 1'b1, 16);
    repeat (40) @(posedge clk_in);
    rd(AST_OFF_STAT, 32'h7, 32'h1);
    rd(AST_OFF_RXD, 32'hff, 32'h3c);
    chk(32'(rx_irqs), 32'h1);
    u_ast_peer.send(8'h81, 1'b0, 16);
    repeat (40) @(posedge clk_in);
    rd(AST_OFF_STAT, 32'h5, 32'h5);
    rd(AST_OFF_RXD, 32'hff, 32'h81);
    rd(AST_OFF_STAT, 32'h5, 32'h0);
    // Five frames into a four-deep queue
    for (int i = 0; i < 5; i++) u_ast_peer.send(8'(i + 1), 1'b1, 16);
    repeat (40) @(posedge clk_in);
    rd(AST_OFF_STAT, 32'h3, 32'h3);
    rd(AST_OFF_RXD, 32'hff, 32'h1);
    rd(AST_OFF_STAT, 32'h2, 32'h2);
    apb(1'b1, AST_OFF_STAT, 32'h4400);
    rd(AST_OFF_STAT, 32'h2, 32'h0);
    // Break on a dummy write, then the sync byte
    apb(1'b1, AST_OFF_STAT, 32'h4c00);
    fork
      u_ast_peer.low_len(n);
    join_none
    apb(1'b1, AST_OFF_TXD, 32'hff);
    apb(1'b1, AST_OFF_TXD, 32'h55);
    wait fork;
    chk(32'(n), 32'(13 * 16));
    u_ast_peer.recv(d, 16);
    chk({23'h0, d}, 32'h155);
    rd(AST_OFF_STAT, 32'h800, 32'h0);
    // Start-bit width at standard and high speed
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, AST_OFF_MODE, mode_v[k]);
      apb(1'b1, AST_OFF_DIV, 32'(div_v[k]));
      fork
        u_ast_peer.low_len(n);
      join_none
      apb(1'b1, AST_OFF_TXD, 32'h1);
      wait fork;
      chk(32'(n), 32'(bp_v[k]));
      repeat (bp_v[k] * 10) @(posedge clk_in);
    end
    // Clear-to-send gates the start; request pin follows the receive queue
    cts_n <= 1'b1;
    apb(1'b1, AST_OFF_MODE, 32'h8208);
    apb(1'b1, AST_OFF_TXD, 32'h7);
    repeat (20) @(posedge clk_in);
    rd(AST_OFF_STAT, 32'h100, 32'h0);
    chk({31'h0, sout}, 32'h1);
    chk({31'h0, rts_n}, 32'h0);
    cts_n <= 1'b0;
    u_ast_peer.recv(d, 8);
    chk({23'h0, d}, 32'h107);
    u_ast_peer.send(8'h5a, 1'b1, 8);
    repeat (20) @(posedge clk_in);
    chk({31'h0, rts_n}, 32'h1);
    // Baud clock on the request pin at standard speed, held low at high speed
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, AST_OFF_MODE, (k == 1) ? 32'h8308 : 32'h8300);
      @(posedge clk_in);
      n = 0;
      repeat (40) begin
        @(posedge clk_in);
        n += int'(rts_n);
      end
      chk(32'(n), (k == 1) ? 32'h0 : 32'h14);
    end
    stop_test();
  end
endmodule
